// File: rtl/tbs_backplane_timing.sv
`timescale 1ns/10ps
module tbs_backplane_timing
  import tbs_pkg::*;
(
  input  wire logic        clk,               // System clock, 25 MHz.
  input  wire logic        reset_n,           // Synchronous reset, active low.
  input  wire logic        psel,              // APB select.
  input  wire logic        penable,           // APB access phase.
  input  wire logic        pwrite,            // APB write.
  input  wire logic [7:0]  paddr,             // APB byte address.
  input  wire logic [31:0] pwdata,            // APB write data.
  output logic      [31:0] prdata,            // APB read data.
  output logic             pready,            // APB ready.
  output logic             pslverr,           // APB error on unmapped address.
  input  wire logic        rxLineClock,       // Receive line bit clock pin.
  input  wire logic        rxLineData,        // Receive framed data pin.
  input  wire logic        rxLineFrame,       // Receive multiframe start pin.
  input  wire logic        rxSysClock,        // Receive backplane bit clock pin.
  input  wire logic        rxFrameSyncIn,     // Receive sync pin, input level.
  output logic             rxFrameSyncOut,    // Receive sync pin, driven level.
  output logic             rxFrameSyncOe,     // Receive sync pin enable.
  output logic             rxSerialData,      // Receive backplane data.
  output logic             rxChannelBlock,    // Receive channel block.
  output logic             rxChannelClock,    // Receive channel clock.
  output logic             rxLinkData,        // Receive data link bit.
  output logic             rxLinkClock,       // Receive data link clock.
  input  wire logic        txSysClock,        // Transmit backplane bit clock pin.
  input  wire logic        txFrameSyncIn,     // Transmit sync pin, input level.
  output logic             txFrameSyncOut,    // Transmit sync pin, driven level.
  output logic             txFrameSyncOe,     // Transmit sync pin enable.
  output logic             txChannelBlock,    // Transmit channel block.
  input  wire logic        txLineClock,       // Transmit line bit clock pin.
  input  wire logic        txFormatterSync,   // Transmit formatter multiframe pin.
  input  wire logic        txLinkData,        // Transmit data link pin.
  output logic             txLinkClock,       // Transmit data link clock.
  output logic             txLinkBit,         // Sampled link bit to formatter.
  output logic             txLinkInsert,      // Pulse: insert txLinkBit.
  input  wire logic        txSignalingInput,  // Transmit signaling pin.
  output logic             txSignalingData,   // Sampled signaling bit.
  output logic             txSignalingValid   // Pulse: signaling bit accepted.
);

  // Advances a frame position; wraps the bit index and the frame number.
  function automatic logic [13:0] stepPos(input logic [8:0] idx, input logic [4:0] fr,
                                          input logic [8:0] len, input logic [4:0] mfLen);
    logic [4:0] nf;
    nf = (fr == mfLen - 5'h01) ? 5'h00 : fr + 5'h01;
    if (idx == len - 9'h001) begin
      stepPos = {nf, 9'h000};
    end else begin
      stepPos = {fr, idx + 9'h001};
    end
  endfunction : stepPos

  // Splits a bit index into F flag, channel and bit within channel.
  function automatic logic [8:0] chanOf(input logic [8:0] idx, input logic wide);
    logic [8:0] rel;
    rel = wide ? idx : idx - 9'h001;
    chanOf = {(!wide && idx == 9'h000), rel[7:3], rel[2:0]};
  endfunction : chanOf

  // Sync pattern for frame, double-width frame pulse or multiframe mode.
  function automatic logic syncAt(input logic [8:0] idx, input logic [4:0] fr,
                                  input logic [8:0] len, input logic mf, input logic dbl);
    if (mf) begin
      syncAt = (idx == 9'h000) && (fr == 5'h00);
    end else begin
      syncAt = (idx == 9'h000) || (dbl && idx == len - 9'h001);
    end
  endfunction : syncAt

  logic [6:0]  rxCtrl;
  logic [6:0]  txCtrl;
  logic [31:0] rxBlockMask;
  logic [31:0] txBlockMask;
  logic [SY_COUNT-1:0] pinRaw;
  logic [SY_COUNT-1:0] syncA;
  logic [SY_COUNT-1:0] syncB;
  logic [SY_COUNT-1:0] syncC;

  // Every pin passes two flops; the third flop only feeds edge detection.
  assign pinRaw = {txSignalingInput, txLinkData, txFormatterSync, txLineClock,
                   txFrameSyncIn, txSysClock, rxFrameSyncIn, rxSysClock,
                   rxLineFrame, rxLineData, rxLineClock};

  // Two-flop synchronisers, one lane per pin.
  genvar g;
  generate
    for (g = 0; g < SY_COUNT; g++) begin : gSync
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
          syncC[g] <= 1'b0;
        end else begin
          syncA[g] <= pinRaw[g];
          syncB[g] <= syncA[g];
          syncC[g] <= syncB[g];
        end
      end
    end
  endgenerate

  // Rising edges of the bit clocks act as bit-time enables.
  logic rxLineTick;
  logic rxSysTick;
  logic txSysTick;
  logic txLineTick;
  assign rxLineTick = syncB[SY_RXLCLK] & ~syncC[SY_RXLCLK];
  assign rxSysTick  = syncB[SY_RXSCLK] & ~syncC[SY_RXSCLK];
  assign txSysTick  = syncB[SY_TXSCLK] & ~syncC[SY_TXSCLK];
  assign txLineTick = syncB[SY_TXLCLK] & ~syncC[SY_TXLCLK];

  // APB decode; the slave never inserts wait states.
  logic apbSetup;
  logic apbWrite;
  logic hitRxCtrl;
  logic hitTxCtrl;
  logic hitRxBlock;
  logic hitTxBlock;
  logic hitStatus;
  logic hitAny;
  assign apbSetup   = psel & ~penable;
  assign apbWrite   = psel & penable & pwrite;
  assign hitRxCtrl  = paddr == ADDR_RX_CTRL;
  assign hitTxCtrl  = paddr == ADDR_TX_CTRL;
  assign hitRxBlock = paddr == ADDR_RX_BLOCK;
  assign hitTxBlock = paddr == ADDR_TX_BLOCK;
  assign hitStatus  = paddr == ADDR_STATUS;
  assign hitAny     = hitRxCtrl | hitTxCtrl | hitRxBlock | hitTxBlock | hitStatus;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~hitAny;

  // Control registers; writes to unmapped or status addresses are dropped.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxCtrl      <= RX_CTRL_RESET;
      txCtrl      <= TX_CTRL_RESET;
      rxBlockMask <= BLOCK_RESET;
      txBlockMask <= BLOCK_RESET;
    end else if (apbWrite) begin
      if (hitRxCtrl)  rxCtrl      <= pwdata[6:0];
      if (hitTxCtrl)  txCtrl      <= pwdata[6:0];
      if (hitRxBlock) rxBlockMask <= pwdata;
      if (hitTxBlock) txBlockMask <= pwdata;
    end
  end

  // Receive mode decoding.
  logic       rxWide;
  logic [8:0] rxBpLen;
  logic [4:0] rxMfLen;
  logic       rxTarget;
  assign rxWide  = rxCtrl[RX_WIDE] & rxCtrl[RX_ELAST];
  assign rxBpLen = rxWide ? FRAME_BITS_WIDE : FRAME_BITS_T1;
  assign rxMfLen = rxCtrl[RX_ESF] ? MF_FRAMES_ESF : MF_FRAMES_D4;

  // Line-side receive position, aligned by the framer's multiframe pulse.
  logic [8:0]  lnIdx;
  logic [4:0]  lnFr;
  logic [13:0] lnNext;
  logic [13:0] lnStep;
  assign lnStep = stepPos(lnIdx, lnFr, FRAME_BITS_T1, rxMfLen);
  assign lnNext = syncB[SY_RXLFRM] ? 14'h0000 : lnStep;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lnIdx <= 9'h000;
      lnFr  <= 5'h00;
    end else if (rxLineTick) begin
      {lnFr, lnIdx} <= lnNext;
    end
  end

  // Frames that carry a link bit: Fs before even, FDL before odd, Z every fourth.
  function automatic logic rxLinkFrame(input logic [4:0] fr, input logic esf,
                                       input logic zb);
    if (!esf) begin
      rxLinkFrame = fr[0];
    end else if (zb) begin
      rxLinkFrame = fr[1:0] == 2'b00;
    end else begin
      rxLinkFrame = !fr[0];
    end
  endfunction : rxLinkFrame

  // The target is the frame after the current one; the update lands in the last bit before it.
  logic [13:0] lnWrap;
  assign lnWrap   = stepPos(FRAME_BITS_T1 - 9'h001, lnFr, FRAME_BITS_T1, rxMfLen);
  assign rxTarget = rxLinkFrame(lnWrap[13:9], rxCtrl[RX_ESF], rxCtrl[RX_ZEROBYTE]);

  // Receive link runs on line timing whatever the elastic store does.
  logic rxLinkPend;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxLinkPend  <= 1'b0;
      rxLinkData  <= 1'b0;
      rxLinkClock <= 1'b0;
    end else if (rxLineTick) begin
      if (lnNext[8:0] == 9'h000 &&
          rxLinkFrame(lnNext[13:9], rxCtrl[RX_ESF], rxCtrl[RX_ZEROBYTE])) begin
        rxLinkPend <= syncB[SY_RXLDAT];
      end
      // Update lands one bit time ahead of the target frame's F bit.
      if (lnIdx == FRAME_BITS_T1 - 9'h002 && rxTarget) begin
        rxLinkData  <= rxLinkPend;
        rxLinkClock <= 1'b1;
      end else begin
        rxLinkClock <= 1'b0;
      end
    end
  end

  // Backplane receive position: follows the line without the elastic store,
  // otherwise runs on the backplane clock and is realigned by an input sync.
  logic [8:0]  bpIdx;
  logic [4:0]  bpFr;
  logic        bpTick;
  logic        rxSyncPrev;
  logic        rxSyncEdge;
  logic [13:0] bpResync;
  logic [13:0] bpNext;
  assign bpTick     = rxCtrl[RX_ELAST] ? rxSysTick : rxLineTick;
  assign rxSyncEdge = rxCtrl[RX_SYNCIN] & syncB[SY_RXSYNC] & ~rxSyncPrev;
  assign bpResync   = rxCtrl[RX_MF] ? 14'h0000 :
                      stepPos(rxBpLen - 9'h001, bpFr, rxBpLen, rxMfLen);
  assign bpNext     = !rxCtrl[RX_ELAST] ? lnNext :
                      rxSyncEdge ? bpResync : stepPos(bpIdx, bpFr, rxBpLen, rxMfLen);

  // Decoded channel of the backplane bit about to be presented.
  logic [8:0] bpChan;
  logic       bpIsF;
  logic [4:0] bpCh;
  logic [2:0] bpBit;
  logic       bpFiller;
  logic       bpFBit;
  assign bpChan   = chanOf(bpNext[8:0], rxWide);
  assign bpIsF    = bpChan[8];
  assign bpCh     = bpChan[7:3];
  assign bpBit    = bpChan[2:0];
  assign bpFiller = rxWide && bpCh[1:0] == 2'b00;
  assign bpFBit   = rxWide && bpCh == 5'h00 && bpBit == 3'h0;

  // Receive backplane outputs, updated once per backplane bit time.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bpIdx          <= 9'h000;
      bpFr           <= 5'h00;
      rxSyncPrev     <= 1'b0;
      rxFrameSyncOut <= 1'b0;
      rxSerialData   <= 1'b0;
      rxChannelBlock <= 1'b0;
      rxChannelClock <= 1'b0;
    end else if (bpTick) begin
      {bpFr, bpIdx}  <= bpNext;
      rxSyncPrev     <= syncB[SY_RXSYNC];
      rxFrameSyncOut <= syncAt(bpNext[8:0], bpNext[13:9], rxBpLen,
                               rxCtrl[RX_MF], rxCtrl[RX_DOUBLE]);
      // Filler channels read as ones except the carried F bit.
      rxSerialData   <= (bpFiller && !bpFBit) ? 1'b1 : syncB[SY_RXLDAT];
      rxChannelBlock <= !bpIsF && (rxBlockMask[bpCh] || bpFiller);
      rxChannelClock <= !bpIsF && bpBit == 3'h0 && !bpFiller;
    end
  end

  // Drive the receive sync pin only in output mode.
  assign rxFrameSyncOe = ~rxCtrl[RX_SYNCIN];

  // Transmit backplane position, realigned by the sync pin in input mode.
  logic [4:0]  txMfLen;
  logic [8:0]  tbIdx;
  logic [4:0]  tbFr;
  logic        txSyncPrev;
  logic        txSyncEdge;
  logic [13:0] tbResync;
  logic [13:0] tbNext;
  logic [8:0]  tbChan;
  logic        tbBlocked;
  assign txMfLen    = txCtrl[TX_ESF] ? MF_FRAMES_ESF : MF_FRAMES_D4;
  assign txSyncEdge = ~txCtrl[TX_SYNCOUT] & syncB[SY_TXSYNC] & ~txSyncPrev;
  assign tbResync   = txCtrl[TX_MF] ? 14'h0000 :
                      stepPos(FRAME_BITS_T1 - 9'h001, tbFr, FRAME_BITS_T1, txMfLen);
  assign tbNext     = txSyncEdge ? tbResync :
                      stepPos(tbIdx, tbFr, FRAME_BITS_T1, txMfLen);
  assign tbChan     = chanOf(tbNext[8:0], 1'b0);
  assign tbBlocked  = !tbChan[8] && txBlockMask[tbChan[7:3]];

  // Transmit backplane outputs and signaling capture.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tbIdx            <= 9'h000;
      tbFr             <= 5'h00;
      txSyncPrev       <= 1'b0;
      txFrameSyncOut   <= 1'b0;
      txChannelBlock   <= 1'b0;
      txSignalingData  <= 1'b0;
      txSignalingValid <= 1'b0;
    end else if (txSysTick) begin
      {tbFr, tbIdx}    <= tbNext;
      txSyncPrev       <= syncB[SY_TXSYNC];
      txFrameSyncOut   <= syncAt(tbNext[8:0], tbNext[13:9], FRAME_BITS_T1,
                                 txCtrl[TX_MF], txCtrl[TX_DOUBLE]);
      txChannelBlock   <= tbBlocked;
      txSignalingData  <= syncB[SY_TXSIG];
      // Blocked channels keep their old signaling when per-channel insert is on.
      txSignalingValid <= !tbChan[8] && !(txCtrl[TX_PCSI] && tbBlocked);
    end else begin
      txSignalingValid <= 1'b0;
    end
  end

  // Drive the transmit sync pin only in output mode.
  assign txFrameSyncOe = txCtrl[TX_SYNCOUT];

  // Transmit link position on the line clock, aligned by the formatter sync.
  logic [8:0]  tlIdx;
  logic [4:0]  tlFr;
  logic [13:0] tlNext;
  logic [13:0] tlStep;
  logic        txTargetNow;
  logic        txTargetNext;
  assign tlStep = stepPos(tlIdx, tlFr, FRAME_BITS_T1, txMfLen);
  assign tlNext = syncB[SY_TXFSYN] ? 14'h0000 : tlStep;

  // Frame numbers are counted from zero, so frame one is index zero.
  function automatic logic txLinkFrame(input logic [4:0] fr, input logic esf,
                                       input logic zb);
    if (!esf) begin
      txLinkFrame = fr[0];
    end else if (zb) begin
      txLinkFrame = fr[1:0] == 2'b00 && fr <= ZB_LAST_FRAME;
    end else begin
      txLinkFrame = !fr[0];
    end
  endfunction : txLinkFrame

  assign txTargetNow  = tlNext[8:0] == 9'h000 &&
                        txLinkFrame(tlNext[13:9], txCtrl[TX_ESF], txCtrl[TX_ZEROBYTE]);
  assign txTargetNext = tlNext[8:0] == FRAME_BITS_T1 - 9'h001 &&
                        txLinkFrame(tlStep[13:9] == txMfLen - 5'h01 ? 5'h00 :
                                    tlNext[13:9] + 5'h01,
                                    txCtrl[TX_ESF], txCtrl[TX_ZEROBYTE]);

  // The link clock asks for a bit one bit time before it is sampled at the F bit.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tlIdx        <= 9'h000;
      tlFr         <= 5'h00;
      txLinkClock  <= 1'b0;
      txLinkBit    <= 1'b0;
      txLinkInsert <= 1'b0;
    end else if (txLineTick) begin
      {tlFr, tlIdx} <= tlNext;
      txLinkClock   <= txTargetNext;
      if (txTargetNow) begin
        txLinkBit <= syncB[SY_TXLINK];
      end
      txLinkInsert  <= txTargetNow && txCtrl[TX_LINKINS];
    end else begin
      txLinkInsert  <= 1'b0;
    end
  end

  // Read data is captured in the setup phase so the access phase needs no wait.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup) begin
      prdata <= hitRxCtrl  ? {25'h0000000, rxCtrl} :
                hitTxCtrl  ? {25'h0000000, txCtrl} :
                hitRxBlock ? rxBlockMask :
                hitTxBlock ? txBlockMask :
                hitStatus  ? {17'h00000, tlFr, bpFr, lnFr} : 32'h0000_0000;
    end
  end

endmodule : tbs_backplane_timing

// File: rtl/tbs_pkg.sv
package tbs_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_RX_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_TX_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_RX_BLOCK = 8'h08;
  localparam logic [7:0] ADDR_TX_BLOCK = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  // Receive control fields.
  localparam int RX_MF     = 0;
  localparam int RX_DOUBLE = 1;
  localparam int RX_SYNCIN = 2;
  localparam int RX_ZEROBYTE = 3;
  localparam int RX_ESF    = 4;
  localparam int RX_ELAST  = 5;
  localparam int RX_WIDE   = 6;
  // Transmit control fields.
  localparam int TX_MF     = 0;
  localparam int TX_DOUBLE = 1;
  localparam int TX_SYNCOUT = 2;
  localparam int TX_ZEROBYTE = 3;
  localparam int TX_LINKINS = 4;
  localparam int TX_PCSI   = 5;
  localparam int TX_ESF    = 6;
  // Reset values.
  localparam logic [6:0]  RX_CTRL_RESET = 7'h00;
  localparam logic [6:0]  TX_CTRL_RESET = 7'h00;
  localparam logic [31:0] BLOCK_RESET   = 32'h0000_0000;
  // Frame geometry.
  localparam logic [8:0] FRAME_BITS_T1   = 9'h0C1;
  localparam logic [8:0] FRAME_BITS_WIDE = 9'h100;
  localparam logic [4:0] MF_FRAMES_D4    = 5'h0C;
  localparam logic [4:0] MF_FRAMES_ESF   = 5'h18;
  localparam logic [4:0] ZB_LAST_FRAME   = 5'h14;
  // Pin synchroniser lanes.
  localparam int SY_RXLCLK = 0;
  localparam int SY_RXLDAT = 1;
  localparam int SY_RXLFRM = 2;
  localparam int SY_RXSCLK = 3;
  localparam int SY_RXSYNC = 4;
  localparam int SY_TXSCLK = 5;
  localparam int SY_TXSYNC = 6;
  localparam int SY_TXLCLK = 7;
  localparam int SY_TXFSYN = 8;
  localparam int SY_TXLINK = 9;
  localparam int SY_TXSIG  = 10;
  localparam int SY_COUNT  = 11;
endpackage : tbs_pkg

// File: test/tbs_backplane_timing_monitor.sv
`timescale 1ns/10ps
module tbs_backplane_timing_monitor
  import tbs_pkg::*;
(
  input wire logic        clk,            // System clock.
  input wire logic        reset_n,        // Synchronous reset, active low.
  input wire logic        psel,           // APB select.
  input wire logic        penable,        // APB access phase.
  input wire logic        pwrite,         // APB write.
  input wire logic [7:0]  paddr,          // APB byte address.
  input wire logic [31:0] pwdata,         // APB write data.
  input wire logic [31:0] prdata,         // APB read data.
  input wire logic        pready,         // APB ready.
  input wire logic        pslverr,        // APB error.
  input wire logic        rxFrameSyncOut, // Receive sync level.
  input wire logic        rxFrameSyncOe,  // Receive sync enable.
  input wire logic        txFrameSyncOut, // Transmit sync level.
  input wire logic        txFrameSyncOe,  // Transmit sync enable.
  input wire logic        txLinkInsert    // Link insert strobe.
);
  // Every check lives in the system clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Bus side: zero wait states, errors only in the access phase, and errors on unmapped places above status.
  ready_high_a: assert property (pready) else $error("ready dropped");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray error");
  unmap_err_a: assert property (psel && penable && paddr > ADDR_STATUS |-> pslverr)
    else $error("unmapped access accepted");
  unmap_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Pin direction follows the control bit from the cycle after the write.
  rx_oe_a: assert property (
    psel && penable && pwrite && paddr == ADDR_RX_CTRL
    |=> rxFrameSyncOe == !$past(pwdata[RX_SYNCIN])) else $error("rx sync direction");
  tx_oe_a: assert property (
    psel && penable && pwrite && paddr == ADDR_TX_CTRL
    |=> txFrameSyncOe == $past(pwdata[TX_SYNCOUT])) else $error("tx sync direction");
  // A driven sync pulse lasts one or two bit times of eight clocks each.
  rx_width_a: assert property ($rose(rxFrameSyncOut) && rxFrameSyncOe |->
    rxFrameSyncOut[*8] ##[1:9] !rxFrameSyncOut) else $error("rx sync width");
  tx_width_a: assert property ($rose(txFrameSyncOut) && txFrameSyncOe |->
    txFrameSyncOut[*8] ##[1:9] !txFrameSyncOut) else $error("tx sync width");
  ins_pulse_a: assert property (txLinkInsert |=> !txLinkInsert)
    else $error("insert strobe too long");
endmodule : tbs_backplane_timing_monitor

// File: test/tbs_line_model.sv
`timescale 1ns/10ps
module tbs_line_model (
  output logic bitClock,   // Line and backplane bit clock, 320 ns.
  output logic lineData,   // Receive line data.
  output logic frameStart, // High through the F bit of frame 1.
  output logic linkData,   // Transmit link data.
  output logic sigData     // Transmit signaling data.
);
  localparam int SUPER = 193 * 24;
  int bitNum;
  // Data moves on the falling bit edge so it is steady at the rising one.
  // The 7 ns offset keeps the bit clock out of phase with the system clock.
  initial begin
    bitClock = 1'b0;
    bitNum = SUPER - 16;
    frameStart = 1'b0;
    lineData = 1'b0;
    linkData = 1'b0;
    sigData = 1'b0;
    #7;
    forever begin
      #160 bitClock = 1'b1;
      #160 bitClock = 1'b0;
      bitNum = (bitNum + 1) % SUPER;
      frameStart = (bitNum == 0);
      lineData = bitNum[0] ^ bitNum[3];
      linkData = bitNum[2];
      sigData = bitNum[1];
    end
  end
endmodule : tbs_line_model

// File: test/tbs_backplane_timing_tb.sv
`timescale 1ns/10ps
module tbs_backplane_timing_tb;
  import tbs_pkg::*;
  localparam int FRAME = 1544; // 193 bits of eight clocks.
  localparam int LIMIT = 90000;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        bitClock, lineData, frameStart, linkData, sigData;
  logic        rxSyncOut, rxSyncOe, rxSerial, rxBlock, rxChClk, rxLinkClk;
  logic        txSyncOut, txSyncOe, txBlock, txInsert, txSigValid, txLinkClk;
  wire         rxSyncPin, txSyncPin;
  wire  [9:0]  probe;
  int          n_errors, compares, cycles;
  int          hi[10];
  int          rs[10];
  // Both sync pins carry pull-downs, so an undriven pin reads low.
  assign rxSyncPin = rxSyncOe ? rxSyncOut : 1'b0;
  assign txSyncPin = txSyncOe ? txSyncOut : 1'b0;
  // Watched lines, one counter slot each.
  // The carried F bit coincides with the sync pulse, so it is kept out of slot 6.
  assign probe = {txLinkClk, rxLinkClk, txSigValid, rxBlock & ~rxSerial & ~rxSyncOut,
                  txInsert, rxChClk, txBlock, rxBlock, txSyncOut, rxSyncOut};
  tbs_line_model tbs_line_model_inst (.bitClock, .lineData, .frameStart, .linkData, .sigData);
  tbs_backplane_timing tbs_backplane_timing_inst (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rxLineClock(bitClock), .rxLineData(lineData), .rxLineFrame(frameStart),
    .rxSysClock(bitClock), .rxFrameSyncIn(rxSyncPin), .rxFrameSyncOut(rxSyncOut),
    .rxFrameSyncOe(rxSyncOe), .rxSerialData(rxSerial), .rxChannelBlock(rxBlock),
    .rxChannelClock(rxChClk), .rxLinkData(), .rxLinkClock(rxLinkClk), .txSysClock(bitClock),
    .txFrameSyncIn(txSyncPin), .txFrameSyncOut(txSyncOut), .txFrameSyncOe(txSyncOe),
    .txChannelBlock(txBlock), .txLineClock(bitClock), .txFormatterSync(frameStart),
    .txLinkData(linkData), .txLinkClock(txLinkClk), .txLinkBit(), .txLinkInsert(txInsert),
    .txSignalingInput(sigData), .txSignalingData(), .txSignalingValid(txSigValid));
  always #20 clk = ~clk;
  function automatic logic [31:0] onehot(input int n);
    return 32'h0000_0001 << n;
  endfunction : onehot
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s is %0h, expected %0h", $time, what, got, exp);
    end
  endtask : check
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, exp, "read data");
    check({31'h0, e}, {31'h0, expErr}, "error flag");
  endtask : reg_rd
  // Counts high clocks and rising edges over n clocks, sampled mid-cycle.
  // Windows are whole periods, so the counts do not depend on phase.
  task automatic measure(input int n);
    logic [9:0] prv;
    for (int i = 0; i < 10; i++) begin
      hi[i] = 0;
      rs[i] = 0;
    end
    @(negedge clk);
    prv = probe;
    repeat (n) begin
      @(negedge clk);
      for (int i = 0; i < 10; i++) begin
        hi[i] += int'(probe[i]);
        rs[i] += int'(probe[i] & ~prv[i]);
      end
      prv = probe;
    end
  endtask : measure
  task automatic run(input logic [31:0] rx, input logic [31:0] tx, input logic [31:0] rb,
                     input logic [31:0] txb, input int n);
    reg_wr(ADDR_RX_CTRL, rx);
    reg_wr(ADDR_TX_CTRL, tx);
    reg_wr(ADDR_RX_BLOCK, rb);
    reg_wr(ADDR_TX_BLOCK, txb);
    repeat (FRAME) @(posedge clk);
    measure(n);
  endtask : run
  // Bounds the run; the tests take about 70000 clocks.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: run did not finish", $time);
      give_verdict();
    end
  end
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {n_errors, compares, cycles} = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    reg_rd(ADDR_RX_CTRL, {25'h0, RX_CTRL_RESET}, 1'b0);
    reg_rd(ADDR_TX_CTRL, {25'h0, TX_CTRL_RESET}, 1'b0);
    reg_rd(ADDR_RX_BLOCK, BLOCK_RESET, 1'b0);
    check({31'h0, rxSyncOe}, 32'h1, "rx sync enable");
    check({31'h0, txSyncOe}, 32'h0, "tx sync enable");
    reg_wr(ADDR_RX_CTRL, 32'hFFFF_FFFF);
    reg_wr(ADDR_TX_CTRL, 32'hFFFF_FFFF);
    reg_wr(ADDR_TX_BLOCK, 32'h00A5_5A81);
    reg_rd(ADDR_RX_CTRL, 32'h0000_007F, 1'b0);
    reg_rd(ADDR_TX_CTRL, 32'h0000_007F, 1'b0);
    reg_rd(ADDR_TX_BLOCK, 32'h00A5_5A81, 1'b0);
    reg_rd(8'h14, 32'h0000_0000, 1'b1);
    check({31'h0, rxSyncOe}, 32'h0, "rx sync enable");
    check({31'h0, txSyncOe}, 32'h1, "tx sync enable");
    $display("test registers done");
    run(32'h0, onehot(TX_SYNCOUT), onehot(23), onehot(1), FRAME);
    check(rs[0], 1, "rx sync pulses");
    check(hi[0], 8, "rx sync width");
    check(rs[1], 1, "tx sync pulses");
    check(hi[1], 8, "tx sync width");
    check(hi[2], 64, "rx block clocks");
    check(hi[3], 64, "tx block clocks");
    check(rs[5], 0, "inserts while disabled");
    check(rs[7], 192, "signaling accepted");
    $display("test single frame sync done");
    run(onehot(RX_DOUBLE), onehot(TX_SYNCOUT) | onehot(TX_DOUBLE) | onehot(TX_PCSI),
        32'h0, onehot(1), FRAME);
    check(hi[0], 16, "rx double width");
    check(hi[1], 16, "tx double width");
    check(rs[7], 184, "signaling accepted");
    $display("test double sync done");
    run(onehot(RX_MF), onehot(TX_SYNCOUT) | onehot(TX_MF) | onehot(TX_LINKINS),
        32'h0, 32'h0, 12 * FRAME);
    check(rs[0], 1, "rx multiframe pulses");
    check(rs[1], 1, "tx multiframe pulses");
    check(rs[5], 6, "fs inserts");
    check(rs[8], 6, "fs link clocks");
    check(rs[9], 6, "fs link requests");
    $display("test multiframe done");
    run(onehot(RX_ESF), onehot(TX_ESF) | onehot(TX_LINKINS), 32'h0, 32'h0, 12 * FRAME);
    check(rs[0], 12, "rx frame pulses");
    check(rs[5], 6, "fdl inserts");
    check(rs[8], 6, "fdl link clocks");
    check(rs[9], 6, "fdl link requests");
    run(onehot(RX_ESF) | onehot(RX_ZEROBYTE),
        onehot(TX_ESF) | onehot(TX_ZEROBYTE) | onehot(TX_LINKINS),
        32'h0, 32'h0, 12 * FRAME);
    check(rs[5], 3, "z inserts");
    check(rs[8], 3, "z link clocks");
    check(rs[9], 3, "z link requests");
    $display("test link sampling done");
    run(onehot(RX_ELAST) | onehot(RX_WIDE), 32'h0, 32'h0, 32'h0, 2048);
    check(hi[2], 512, "filler block clocks");
    check(rs[4], 24, "channel clock pulses");
    check(hi[6], 0, "filler data low");
    check(rs[0], 1, "wide frame pulses");
    $display("test wide backplane done");
    give_verdict();
  end
endmodule : tbs_backplane_timing_tb
bind tbs_backplane_timing tbs_backplane_timing_monitor tbs_backplane_timing_monitor_inst (
  .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .rxFrameSyncOut, .rxFrameSyncOe, .txFrameSyncOut, .txFrameSyncOe, .txLinkInsert);
